// ---- core/block_power_config_map.vh ----
// register map, field positions and reset values of the block power and
// global configuration logic; definitions only, included by bare name
`ifndef BLOCK_POWER_CONFIG_MAP_VH
`define BLOCK_POWER_CONFIG_MAP_VH

// ************************************************************
// register offsets (serial register port word addresses)
// ************************************************************
`define ADDR_GLOBAL_CONFIG      8'h01
`define ADDR_BLOCK_POWER        8'h02
`define ADDR_INT_CONTROL        8'h03
`define ADDR_MONITOR_INTERVAL   8'h04
`define ADDR_DLL_CONTROL        8'h05
`define ADDR_OSC_RESOLUTION     8'h08

// ************************************************************
// field positions
// ************************************************************
`define GC_IRQ_ENABLE           0
`define GC_AUTO_DLL_RESET       1
`define GC_SOFT_RESET           2
`define IC_SRC_LSB              0
`define IC_SRC_MSB              4
`define IC_MASK_LSB             8
`define IC_MASK_MSB             12
`define DLL_DELAY_LSB           0
`define DLL_DELAY_MSB           1
`define DLL_DISABLE_LSB         2
`define DLL_DISABLE_MSB         3
`define RES_SEL_LSB             15
`define RES_SEL_MSB             16

// interrupt source bit order
`define SRC_OVERFLOW            0
`define SRC_UNDERFLOW           1
`define SRC_TEST_MODE           2
`define SRC_MONITOR_TIMER       3
`define SRC_CAPACITY            4

// ************************************************************
// reset values
// ************************************************************
`define RST_IRQ_ENABLE          1'b1
`define RST_AUTO_DLL_RESET      1'b1
`define RST_INT_MASK            5'h1f
`define RST_DLL_DELAY           2'h3
`define RST_DLL_DISABLE         2'h2
`define RST_RES_SEL             2'h0
`define RST_MONITOR_INTERVAL    32'h0000_1000

// four-state driver codes
`define DRV_FLOAT               2'h0
`define DRV_WEAK_LOW            2'h1
`define DRV_LOW                 2'h2
`define DRV_HIGH                2'h3

// converter dll-off pulse length in clock cycles
`define DLL_PULSE_CYCLES        4'h8

`endif

// ---- core/block_power_config_control.v ----
// block power and global configuration control: strap decode into block
// enables, shared power-monitor interval timer, interrupt tree, oscillator
// resolution select and converter dll controls with dll-off pulse.
// assumes a synchronous single-cycle register port on clk, event inputs
// synchronous to clk, and straps stable while arst_n is released.
`default_nettype none
`include "block_power_config_map.vh"

module block_power_config_control
#(
    parameter NUM_CHANNEL_OSC  = 160,   // per-channel oscillators
    parameter NUM_COMBINER_OSC = 20,    // per-combiner oscillators
    parameter NUM_BLOCK_OSC    = 11,    // block-level oscillators, one per block enable
    parameter NUM_OUTPUT_OSC   = 1      // final output oscillator
)
(
    input  wire                     clk,               // core clock
    input  wire                     arst_n,            // global reset, active low
    input  wire [3:0]               strap_cfg,         // strap pins 4..1
    input  wire                     factory_valid,     // factory setup present
    input  wire [NUM_BLOCK_OSC-1:0] factory_blocks,    // factory block enables
    input  wire                     reg_wr,            // register write strobe
    input  wire                     reg_rd,            // register read strobe
    input  wire [7:0]               reg_addr,          // register address
    input  wire [31:0]              reg_wdata,         // write data
    input  wire                     buf_overflow,      // channel buffer overflow event
    input  wire                     buf_underflow,     // channel buffer underflow event
    input  wire                     test_mode_entered, // output test mode event
    input  wire                     capacity_exceeded, // channel capacity exceeded event
    output reg  [31:0]              reg_rdata,         // read data, one cycle after reg_rd
    output reg  [NUM_BLOCK_OSC-1:0] block_enable,      // combiners 1-5, multicarrier 1-6
    output reg                      irq_flag_n,        // interrupt flag, active low
    output reg                      monitor_done,      // monitor window complete pulse
    output reg                      osc_high_res,      // block oscillator 30-bit words
    output reg                      dll_off_pulse,     // converter dll-off reset pulse
    output reg                      dll_delay_oe,      // delay driver enable
    output reg                      dll_delay_out,     // delay driver level
    output reg                      dll_delay_weak,    // delay weak pull to ground
    output reg                      dll_disable_oe,    // disable driver enable
    output reg                      dll_disable_out,   // disable driver level
    output reg                      dll_disable_weak   // disable weak pull to ground
);

    // ************************************************************
    // strap decode table
    // ************************************************************
    // result bits [4:0] combiners 1..5, [10:5] multicarrier 1..6
    function [10:0] strap_decode;
        input [3:0] code;
        begin
            case (code)
                4'h0: strap_decode = {6'h03, 5'h1f};
                4'h1: strap_decode = {6'h03, 5'h0f};
                4'h2: strap_decode = {6'h03, 5'h1e};
                4'h3: strap_decode = {6'h18, 5'h1f};
                4'h4: strap_decode = {6'h18, 5'h0f};
                4'h5: strap_decode = {6'h18, 5'h1e};
                4'h6: strap_decode = {6'h03, 5'h1d};
                4'h7: strap_decode = {6'h03, 5'h1b};
                4'h8: strap_decode = {6'h03, 5'h17};
                4'h9: strap_decode = {6'h07, 5'h0f};
                4'ha: strap_decode = {6'h38, 5'h0f};
                4'hb: strap_decode = {6'h1b, 5'h07};
                4'hc: strap_decode = {6'h1f, 5'h03};
                4'hd: strap_decode = {6'h1f, 5'h01};
                4'he: strap_decode = {6'h3f, 5'h1f};
                default: strap_decode = 11'h000;     // code 15 all off
            endcase
        end
    endfunction

    // ************************************************************
    // register state
    // ************************************************************
    reg        irq_enable_q;
    reg        auto_dll_q;
    reg [4:0]  int_src_q;
    reg [4:0]  int_mask_q;
    reg [31:0] interval_q;
    reg [31:0] count_q;
    reg [1:0]  dll_delay_q;
    reg [1:0]  dll_disable_q;
    reg [1:0]  res_sel_q;
    reg        strap_loaded_q;
    reg [3:0]  pulse_cnt_q;
    reg [31:0] rdata_d;

    wire       wr_gc   = reg_wr && (reg_addr == `ADDR_GLOBAL_CONFIG);
    wire       wr_bp   = reg_wr && (reg_addr == `ADDR_BLOCK_POWER);
    wire       wr_ic   = reg_wr && (reg_addr == `ADDR_INT_CONTROL);
    wire       wr_mi   = reg_wr && (reg_addr == `ADDR_MONITOR_INTERVAL);
    wire       wr_dll  = reg_wr && (reg_addr == `ADDR_DLL_CONTROL);
    wire       wr_res  = reg_wr && (reg_addr == `ADDR_OSC_RESOLUTION);
    // soft reset is a self-clearing command bit, never stored
    wire       soft_rst = wr_gc && reg_wdata[`GC_SOFT_RESET];
    wire       timer_zero = (count_q == 32'h0000_0000);
    wire [4:0] events;

    assign events[`SRC_OVERFLOW]      = buf_overflow;
    assign events[`SRC_UNDERFLOW]     = buf_underflow;
    assign events[`SRC_TEST_MODE]     = test_mode_entered;
    assign events[`SRC_MONITOR_TIMER] = timer_zero;
    assign events[`SRC_CAPACITY]      = capacity_exceeded;

    // ************************************************************
    // global, dll and resolution configuration
    // ************************************************************
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_enable_q  <= `RST_IRQ_ENABLE;
            auto_dll_q    <= `RST_AUTO_DLL_RESET;
            dll_delay_q   <= `RST_DLL_DELAY;
            dll_disable_q <= `RST_DLL_DISABLE;
            res_sel_q     <= `RST_RES_SEL;
            interval_q    <= `RST_MONITOR_INTERVAL;
        end
        else
        begin
            if (wr_gc)
            begin
                irq_enable_q <= reg_wdata[`GC_IRQ_ENABLE];
                auto_dll_q   <= reg_wdata[`GC_AUTO_DLL_RESET];
            end
            if (wr_dll)
            begin
                dll_delay_q   <= reg_wdata[`DLL_DELAY_MSB:`DLL_DELAY_LSB];
                dll_disable_q <= reg_wdata[`DLL_DISABLE_MSB:`DLL_DISABLE_LSB];
            end
            if (wr_res)
                res_sel_q <= reg_wdata[`RES_SEL_MSB:`RES_SEL_LSB];
            if (wr_mi)
                interval_q <= reg_wdata;
        end
    end

    // ************************************************************
    // block power register with strap capture
    // ************************************************************
    // straps are caught on the first edge after release, never under the
    // asynchronous reset itself; a write in that same edge still wins
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            strap_loaded_q <= 1'b0;
            block_enable   <= {NUM_BLOCK_OSC{1'b0}};
        end
        else
        begin
            strap_loaded_q <= 1'b1;
            if (wr_bp)
                block_enable <= reg_wdata[NUM_BLOCK_OSC-1:0];
            else if (!strap_loaded_q)
            begin
                if (factory_valid)
                    block_enable <= factory_blocks;
                else
                    block_enable <= strap_decode(strap_cfg);
            end
        end
    end

    // ************************************************************
    // shared power-monitor interval timer
    // ************************************************************
    // one counter for all monitors so every window ends on the same edge;
    // soft reset restarts the window from the programmed interval
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count_q      <= `RST_MONITOR_INTERVAL;
            monitor_done <= 1'b0;
        end
        else
        begin
            monitor_done <= timer_zero;
            if (soft_rst || timer_zero)
                count_q <= interval_q;
            else
                count_q <= count_q - 32'h0000_0001;
        end
    end

    // ************************************************************
    // interrupt sources, mask and flag
    // ************************************************************
    // a zero written clears a source; an event in the same cycle sets it
    // again, so nothing is lost between the read and the clear
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            int_src_q  <= 5'h00;
            int_mask_q <= `RST_INT_MASK;
            irq_flag_n <= 1'b1;
        end
        else
        begin
            // an event in the soft-reset cycle still latches, set wins
            if (soft_rst)
                int_src_q <= events;
            else if (wr_ic)
                int_src_q <= (int_src_q & reg_wdata[`IC_SRC_MSB:`IC_SRC_LSB]) | events;
            else
                int_src_q <= int_src_q | events;
            if (wr_ic)
                int_mask_q <= reg_wdata[`IC_MASK_MSB:`IC_MASK_LSB];
            irq_flag_n <= !(irq_enable_q && |(int_src_q & int_mask_q));
        end
    end

    // ************************************************************
    // converter dll-off pulse
    // ************************************************************
    // counter starts loaded, so leaving global reset always yields a pulse
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pulse_cnt_q   <= `DLL_PULSE_CYCLES;
            dll_off_pulse <= 1'b1;
        end
        else
        begin
            if (soft_rst && auto_dll_q)
                pulse_cnt_q <= `DLL_PULSE_CYCLES;
            else if (pulse_cnt_q != 4'h0)
                pulse_cnt_q <= pulse_cnt_q - 4'h1;
            dll_off_pulse <= (soft_rst && auto_dll_q) || (pulse_cnt_q > 4'h1);
        end
    end

    // ************************************************************
    // four-state driver outputs and resolution select
    // ************************************************************
    // oe high drives the level; oe low with weak set means a pull to ground
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dll_delay_oe     <= 1'b0;
            dll_delay_out    <= 1'b0;
            dll_delay_weak   <= 1'b0;
            dll_disable_oe   <= 1'b0;
            dll_disable_out  <= 1'b0;
            dll_disable_weak <= 1'b0;
            osc_high_res     <= 1'b0;
        end
        else
        begin
            dll_delay_oe     <= dll_delay_q[1];
            dll_delay_out    <= (dll_delay_q == `DRV_HIGH);
            dll_delay_weak   <= (dll_delay_q == `DRV_WEAK_LOW);
            dll_disable_oe   <= dll_disable_q[1];
            dll_disable_out  <= (dll_disable_q == `DRV_HIGH);
            dll_disable_weak <= (dll_disable_q == `DRV_WEAK_LOW);
            osc_high_res     <= (res_sel_q != `RST_RES_SEL);
        end
    end

    // ************************************************************
    // register read path
    // ************************************************************
    always @*
    begin
        rdata_d = 32'h0000_0000;
        case (reg_addr)
            `ADDR_GLOBAL_CONFIG:
            begin
                rdata_d[`GC_IRQ_ENABLE]     = irq_enable_q;
                rdata_d[`GC_AUTO_DLL_RESET] = auto_dll_q;
            end
            `ADDR_BLOCK_POWER:
                rdata_d[NUM_BLOCK_OSC-1:0] = block_enable;
            `ADDR_INT_CONTROL:
            begin
                rdata_d[`IC_SRC_MSB:`IC_SRC_LSB]   = int_src_q;
                rdata_d[`IC_MASK_MSB:`IC_MASK_LSB] = int_mask_q;
            end
            `ADDR_MONITOR_INTERVAL:
                rdata_d = interval_q;
            `ADDR_DLL_CONTROL:
            begin
                rdata_d[`DLL_DELAY_MSB:`DLL_DELAY_LSB]     = dll_delay_q;
                rdata_d[`DLL_DISABLE_MSB:`DLL_DISABLE_LSB] = dll_disable_q;
            end
            `ADDR_OSC_RESOLUTION:
                rdata_d[`RES_SEL_MSB:`RES_SEL_LSB] = res_sel_q;
            default:
                rdata_d = 32'h0000_0000; // unmapped reads return zero
        endcase
    end

    // read data holds until the next read strobe
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata <= 32'h0000_0000;
        else if (reg_rd)
            reg_rdata <= rdata_d;
    end

endmodule
`default_nettype wire

// ---- testbench/block_power_config_checker.sv ----
// checker for block power and global configuration control outputs
// assumes it is bound to the top module and sees only its ports
`default_nettype none
module block_power_config_checker
#(
    parameter int NUM_BLOCK_OSC = 11 // block enable width
)
(
    input wire logic                     clk,              // core clock
    input wire logic                     arst_n,           // global reset
    input wire logic                     factory_valid,    // factory setup present
    input wire logic [NUM_BLOCK_OSC-1:0] factory_blocks,   // factory enables
    input wire logic                     reg_wr,           // write strobe
    input wire logic [7:0]               reg_addr,         // address
    input wire logic [31:0]              reg_wdata,        // write data
    input wire logic                     buf_overflow,     // overflow event
    input wire logic [NUM_BLOCK_OSC-1:0] block_enable,     // block enables
    input wire logic                     irq_flag_n,       // flag, active low
    input wire logic                     monitor_done,     // window done
    input wire logic                     osc_high_res,     // resolution mode
    input wire logic                     dll_off_pulse,    // dll-off pulse
    input wire logic                     dll_delay_oe,     // delay enable
    input wire logic                     dll_delay_out,    // delay level
    input wire logic                     dll_delay_weak,   // delay weak pull
    input wire logic                     dll_disable_oe,   // disable enable
    input wire logic                     dll_disable_out,  // disable level
    input wire logic                     dll_disable_weak  // disable weak pull
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    logic       rel_q;  // high from the first edge after reset release
    logic       en_q;   // shadow of the flag enable
    logic       auto_q; // shadow of the auto dll reset enable
    logic [4:0] mask_q; // shadow of the source masks
    logic [3:0] dll_q;  // shadow of disable and delay codes
    logic [1:0] res_q;  // shadow of the resolution field
    logic       gwr;    // global configuration write
    assign gwr = reg_wr && reg_addr == 8'h01;
    // shadows follow writes so outputs can be judged without seeing the bodies
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rel_q  <= 1'b0;
            en_q   <= 1'b1;
            auto_q <= 1'b1;
            mask_q <= 5'h1f;
            dll_q  <= 4'hb;
            res_q  <= 2'h0;
        end
        else
        begin
            rel_q  <= 1'b1;
            en_q   <= gwr ? reg_wdata[0] : en_q;
            auto_q <= gwr ? reg_wdata[1] : auto_q;
            mask_q <= (reg_wr && reg_addr == 8'h03) ? reg_wdata[12:8] : mask_q;
            dll_q  <= (reg_wr && reg_addr == 8'h05) ? reg_wdata[3:0] : dll_q;
            res_q  <= (reg_wr && reg_addr == 8'h08) ? reg_wdata[16:15] : res_q;
        end
    end
    a_block_write: assert property (reg_wr && reg_addr == 8'h02 |=>
        block_enable == $past(reg_wdata[NUM_BLOCK_OSC-1:0])) else $error("block write not applied");
    a_factory_wins: assert property (!rel_q && factory_valid && !(reg_wr && reg_addr == 8'h02) |=>
        block_enable == $past(factory_blocks)) else $error("factory setup not loaded");
    a_boot_pulse: assert property (!rel_q |->
        dll_off_pulse [*7] ##[1:4] !dll_off_pulse) else $error("dll-off pulse wrong after reset");
    a_soft_pulse: assert property (gwr && reg_wdata[2] && auto_q |=>
        dll_off_pulse [*7]) else $error("soft reset gave no dll-off pulse");
    a_no_soft_pulse: assert property (gwr && reg_wdata[2] && !auto_q && !dll_off_pulse |=>
        !dll_off_pulse [*8]) else $error("dll-off pulse with auto enable off");
    a_dll_drive: assert property (rel_q |->
        {dll_delay_oe, dll_delay_out, dll_delay_weak, dll_disable_oe, dll_disable_out, dll_disable_weak} ==
        $past({dll_q[1], &dll_q[1:0], !dll_q[1] & dll_q[0], dll_q[3], &dll_q[3:2], !dll_q[3] & dll_q[2]}))
        else $error("dll driver outputs do not match codes");
    a_res_mode: assert property (rel_q |-> osc_high_res == $past(|res_q))
        else $error("resolution mode does not follow field");
    a_flag_rise: assert property (buf_overflow && en_q && mask_q[0] |-> ##2 !irq_flag_n)
        else $error("flag not raised by overflow");
    a_flag_gate: assert property (!en_q |=> irq_flag_n)
        else $error("flag shown while enable is clear");
    a_monitor_flag: assert property (monitor_done && en_q && mask_q[3] |-> ##[0:2] !irq_flag_n)
        else $error("monitor expiry raised no flag");
    a_done_pulse: assert property (monitor_done |=> !monitor_done)
        else $error("monitor done longer than one cycle");
endmodule
bind block_power_config_control block_power_config_checker #(.NUM_BLOCK_OSC(NUM_BLOCK_OSC)) u_chk (
    .clk(clk), .arst_n(arst_n), .factory_valid(factory_valid), .factory_blocks(factory_blocks),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .buf_overflow(buf_overflow),
    .block_enable(block_enable), .irq_flag_n(irq_flag_n), .monitor_done(monitor_done),
    .osc_high_res(osc_high_res), .dll_off_pulse(dll_off_pulse), .dll_delay_oe(dll_delay_oe),
    .dll_delay_out(dll_delay_out), .dll_delay_weak(dll_delay_weak), .dll_disable_oe(dll_disable_oe),
    .dll_disable_out(dll_disable_out), .dll_disable_weak(dll_disable_weak));
`default_nettype wire

// ---- testbench/strap_board.sv ----
// board model of the four strap pins, each set by a resistor
// assumes the bench sets pin levels while reset is held
`default_nettype none
module strap_board
(
    input  wire logic [4:1] pin_level, // resistor level per pin
    output wire logic [3:0] strap_cfg  // to the device
);
    timeunit 1ns;
    timeprecision 1ps;
    // pin 4 lands on the msb; a swapped board would reverse every code
    assign strap_cfg = {pin_level[4], pin_level[3], pin_level[2], pin_level[1]};
endmodule
`default_nettype wire

// ---- testbench/block_power_config_control_tb.sv ----
// testbench for block power and global configuration control
// assumes the strap board model and the bound checker are compiled first
`default_nettype none
module block_power_config_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [4:1]  pins = 4'h0;
    logic [3:0]  strap_cfg;
    logic        factory_valid = 1'b0;
    logic [10:0] factory_blocks = 11'h000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [3:0]  ev = 4'h0; // overflow, underflow, test mode, capacity
    logic [31:0] reg_rdata;
    logic [10:0] block_enable;
    logic        irq_flag_n;
    logic        monitor_done;
    logic        osc_high_res;
    logic        dll_off_pulse;
    logic [5:0]  drv; // delay oe/out/weak, disable oe/out/weak
    int          failures = 0;
    int          compares = 0;
    int          cycles = 0;
    int          n;
    logic [10:0] strap_exp [16] = '{11'h07f, 11'h06f, 11'h07e, 11'h31f, 11'h30f, 11'h31e, 11'h07d, 11'h07b,
        11'h077, 11'h0ef, 11'h70f, 11'h367, 11'h3e3, 11'h3e1, 11'h7ff, 11'h000};
    logic [7:0]  ra [7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08};
    logic [31:0] rv [7] = '{32'h3, 32'h7f, 32'h1f00, 32'h1000, 32'hb, 32'h0, 32'h0};
    strap_board u_straps (.pin_level(pins), .strap_cfg(strap_cfg));
    block_power_config_control dut (
        .clk(clk), .arst_n(arst_n), .strap_cfg(strap_cfg), .factory_valid(factory_valid),
        .factory_blocks(factory_blocks), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .buf_overflow(ev[0]), .buf_underflow(ev[1]), .test_mode_entered(ev[2]),
        .capacity_exceeded(ev[3]), .reg_rdata(reg_rdata), .block_enable(block_enable),
        .irq_flag_n(irq_flag_n), .monitor_done(monitor_done), .osc_high_res(osc_high_res),
        .dll_off_pulse(dll_off_pulse), .dll_delay_oe(drv[5]), .dll_delay_out(drv[4]),
        .dll_delay_weak(drv[3]), .dll_disable_oe(drv[2]), .dll_disable_out(drv[1]),
        .dll_disable_weak(drv[0]));
    // 250 MHz clock and a ceiling well above the several hundred cycles needed
    always #2 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            report_and_stop;
        end
    end
    task automatic report_and_stop;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
            failures++;
        end
    endtask
    // one access per call; strobes drop one edge later so back-to-back calls stay legal
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk) #1;
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        @(posedge clk) #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clk) #1;
        reg_rd = 1'b0;
        check(name, exp, reg_rdata);
    endtask
    task automatic boot(input logic [3:0] code, input logic fv);
        arst_n = 1'b0;
        pins = code;
        factory_valid = fv;
        repeat (12) @(posedge clk);
        #1 arst_n = 1'b1;
        repeat (12) @(posedge clk);
        #1;
    endtask
    task automatic pulse(input int s);
        @(posedge clk) #1;
        ev[s] = 1'b1;
        @(posedge clk) #1;
        ev[s] = 1'b0;
        @(posedge clk) #1;
    endtask
    function automatic logic [2:0] enc(input logic [1:0] c);
        return {c[1], c[1] & c[0], !c[1] & c[0]};
    endfunction
    // main sequence: reset values, straps, factory, dll, resolution, interrupts, timer
    initial
    begin
        boot(4'h0, 1'b0);
        check("irq_flag_n", 32'h1, {31'h0, irq_flag_n});
        check("dll drivers", 32'h34, {26'h0, drv});
        for (int i = 0; i < 7; i++)
            rd(ra[i], rv[i], $sformatf("register %h", ra[i]));
        for (int c = 0; c < 16; c++)
        begin
            boot(c[3:0], 1'b0);
            check("block_enable", {21'h0, strap_exp[c]}, {21'h0, block_enable});
        end
        factory_blocks = 11'h2a5;
        boot(4'he, 1'b1);
        check("block_enable", 32'h2a5, {21'h0, block_enable});
        wr(8'h02, 32'h155);
        check("block_enable", 32'h155, {21'h0, block_enable});
        rd(8'h02, 32'h155, "block power");
        for (int k = 0; k < 16; k++)
        begin
            wr(8'h05, k);
            @(posedge clk) #1;
            check("dll drivers", {26'h0, enc(k[1:0]), enc(k[3:2])}, {26'h0, drv});
        end
        wr(8'h05, 32'hb);
        for (int f = 0; f < 4; f++)
        begin
            wr(8'h08, f << 15);
            @(posedge clk) #1;
            check("osc_high_res", {31'h0, f != 0}, {31'h0, osc_high_res});
            rd(8'h08, f << 15, "resolution");
        end
        for (int s = 0; s < 4; s++)
        begin
            pulse(s);
            check("irq_flag_n", 32'h0, {31'h0, irq_flag_n});
            rd(8'h03, 32'h1f00 | (s == 3 ? 32'h10 : 32'h1 << s), "sources");
            wr(8'h03, 32'h1f00);
            @(posedge clk) #1;
            check("irq_flag_n", 32'h1, {31'h0, irq_flag_n});
        end
        wr(8'h01, 32'h2);
        pulse(0);
        check("irq_flag_n", 32'h1, {31'h0, irq_flag_n});
        rd(8'h03, 32'h1f01, "sources");
        wr(8'h01, 32'h3);
        @(posedge clk) #1;
        check("irq_flag_n", 32'h0, {31'h0, irq_flag_n});
        wr(8'h03, 32'h1f00);
        wr(8'h04, 32'h8);
        wr(8'h01, 32'h7);
        check("dll_off_pulse", 32'h1, {31'h0, dll_off_pulse});
        n = 0;
        while (monitor_done !== 1'b1 && n < 40)
        begin
            @(posedge clk) #1;
            n++;
        end
        n = 0;
        do
        begin
            @(posedge clk) #1;
            n++;
        end
        while (monitor_done !== 1'b1 && n < 40);
        check("monitor period", 32'd9, n);
        @(posedge clk) #1;
        check("irq_flag_n", 32'h0, {31'h0, irq_flag_n});
        wr(8'h01, 32'h1);
        wr(8'h01, 32'h5);
        repeat (8)
        begin
            check("dll_off_pulse", 32'h0, {31'h0, dll_off_pulse});
            @(posedge clk) #1;
        end
        report_and_stop;
    end
endmodule
`default_nettype wire
